// ---- design/emf_regs.svh ----
/*
  Register offsets, configuration width, reset values, frame figures and timing counts of the
  Ethernet user-stream framing block.
  Assumes inclusion by bare name from the package only; the design module sees its macros from there.
*/
`ifndef EMF_REGS_SVH
`define EMF_REGS_SVH

// ****************************************************************
// register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define EMF_OFF_CFG        8'h00
`define EMF_OFF_MAXLEN     8'h04
`define EMF_OFF_RXGOOD     8'h08
`define EMF_OFF_RXBAD      8'h0C
`define EMF_OFF_TXGOOD     8'h10
`define EMF_OFF_STATUS     8'h14

// ****************************************************************
// configuration fields and reset values
// ****************************************************************
`define EMF_CFG_W          7
`define EMF_CFG_RESET      7'h08
`define EMF_MAXLEN_RESET   16'h05EE

// ****************************************************************
// frame figures
// ****************************************************************
`define EMF_VLAN_TPID      16'h8100
`define EMF_MAX_UNTAGGED   16'h05EE
`define EMF_MAX_TAGGED     16'h05F2
`define EMF_LEN_MIN_FIELD  16'h002E
`define EMF_LEN_TYPE_SPLIT 16'h0600
`define EMF_MIN_FRAME      16'h0040
`define EMF_MIN_NOFCS      16'h003C
`define EMF_HDR_BYTES      16'h000E
`define EMF_HDR_FCS_BYTES  16'h0012
`define EMF_DA_BYTES       16'h0006
`define EMF_FCS_BYTES      16'h0004

// ****************************************************************
// transmit pacing, in clock cycles per byte, and gap in bytes
// ****************************************************************
`define EMF_DIV_1G         7'h01
`define EMF_DIV_100M       7'h0A
`define EMF_DIV_10M        7'h64
`define EMF_IFG_BYTES      4'hC

`endif

// ---- design/emf_pkg.sv ----
/*
  Types of the Ethernet user-stream framing block: bus carriers, stream
  carriers, statistics vectors, configuration and the module state.
  Assumes emf_regs.svh on the include path.
*/
package emf_pkg;
  `include "emf_regs.svh"

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } emf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } emf_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       frame_end;
    logic       fcs_bad;
    logic       phy_err;
    logic       filter_reject;
  } emf_rx_phy_t;

  typedef struct packed {
    logic [7:0] tdata;
    logic       tvalid;
    logic       tlast;
    logic       tuser;
  } emf_axis_t;

  typedef struct packed {
    logic        byte_seen;
    logic [15:0] length;
    logic        vlan;
    logic        fcs_err;
    logic        size_err;
    logic        lt_err;
    logic        filtered;
    logic        good;
  } emf_rx_stat_t;

  typedef struct packed {
    logic [7:0] txd;
    logic       tx_en;
    logic       tx_er;
    logic       append_fcs;
  } emf_tx_phy_t;

  typedef struct packed {
    logic [15:0] length;
    logic        good;
    logic        underrun;
    logic        user_abort;
  } emf_tx_stat_t;

  typedef struct packed {
    logic [1:0] speed;
    logic       tx_fcs_pass;
    logic       lt_check_en;
    logic       maxlen_en;
    logic       jumbo_en;
    logic       rx_fcs_pass;
  } emf_cfg_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_FILL,
    TX_WAIT,
    TX_SEND,
    TX_PAD,
    TX_ERRF,
    TX_IFG
  } emf_tx_st_t;

  typedef struct packed {
    emf_cfg_t     cfg;
    logic [15:0]  maxlen;
    logic [15:0]  rx_good;
    logic [15:0]  rx_bad;
    logic [15:0]  tx_good;
    logic [31:0]  prdata;
    logic [15:0]  rx_n;
    logic [31:0]  rx_sr;
    logic [15:0]  rx_lt;
    logic         rx_vlan;
    logic         rx_rej;
    logic         pend_v;
    logic [7:0]   pend_d;
    emf_axis_t    rx_axis;
    emf_rx_stat_t rx_stat;
    logic         rx_stat_v;
    emf_tx_st_t   tx_st;
    logic [6:0]   tick_cnt;
    logic [15:0]  tx_buf;
    logic [1:0]   buf_n;
    logic         got_last;
    logic         aborted;
    logic [15:0]  tx_cnt;
    logic [3:0]   ifg_cnt;
    emf_tx_phy_t  tx_phy;
    emf_tx_stat_t tx_stat;
    logic         tx_stat_v;
  } emf_state_t;
endpackage : emf_pkg

// ---- design/emf_framing.sv ----
/*
  User-side framing of an Ethernet MAC: receive stream with frame checks,
  padding and FCS handling, statistics; transmit stream with pacing,
  padding and abort handling; APB register slave.
  Assumes a byte-wide PHY-side decoder feeding rx_phy and an encoder taking
  tx_phy, all on pclk.

*/
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module emf_framing
  import emf_pkg::*;
#(
  parameter logic [3:0]  IFG_BYTES   = `EMF_IFG_BYTES,
  parameter logic [15:0] MIN_ERR_LEN = `EMF_MIN_FRAME
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire emf_pkg::emf_apb_req_t apb_req,
  output var  emf_pkg::emf_apb_rsp_t apb_rsp,
  input  wire emf_pkg::emf_rx_phy_t  rx_phy,
  output var  emf_pkg::emf_axis_t    rx_axis,
  output var  emf_pkg::emf_rx_stat_t rx_stat,
  output logic                       rx_stat_valid,
  input  wire emf_pkg::emf_axis_t    tx_axis,
  output logic                       tx_tready,
  output var  emf_pkg::emf_tx_phy_t  tx_phy,
  output var  emf_pkg::emf_tx_stat_t tx_stat,
  output logic                       tx_stat_valid
);
  import emf_pkg::*;

  emf_state_t q;
  emf_state_t d;

  // ****************************************************************
  // combinational next state
  // ****************************************************************
  always_comb
  begin
    logic        mapped;
    logic [31:0] rd;
    logic [15:0] idx;
    logic [15:0] ci;
    logic [7:0]  cand;
    logic        has_cand;
    logic        strip;
    logic        rej_now;
    logic        oversz;
    logic        lterr;
    logic        err;
    logic        tick;
    logic        tready_c;
    logic [6:0]  div;
    logic [15:0] min_len;
    mapped   = 1'b0;
    rd       = 32'h0000_0000;
    idx      = q.rx_n;
    ci       = 16'h0000;
    cand     = 8'h00;
    has_cand = 1'b0;
    strip    = 1'b0;
    rej_now  = 1'b0;
    oversz   = 1'b0;
    lterr    = 1'b0;
    err      = 1'b0;
    tick     = (q.tick_cnt == 7'h00);
    tready_c = 1'b0;
    div      = `EMF_DIV_1G;
    min_len  = q.cfg.tx_fcs_pass ? `EMF_MIN_FRAME : `EMF_MIN_NOFCS;
    d        = q;

    // ****************************************************************
    // apb slave: zero wait states, read data latched in setup phase
    // ****************************************************************
    case (apb_req.paddr)
      `EMF_OFF_CFG:
      begin
        mapped = 1'b1;
        rd     = {25'h0000000, q.cfg};
      end
      `EMF_OFF_MAXLEN:
      begin
        mapped = 1'b1;
        rd     = {16'h0000, q.maxlen};
      end
      `EMF_OFF_RXGOOD:
      begin
        mapped = 1'b1;
        rd     = {16'h0000, q.rx_good};
      end
      `EMF_OFF_RXBAD:
      begin
        mapped = 1'b1;
        rd     = {16'h0000, q.rx_bad};
      end
      `EMF_OFF_TXGOOD:
      begin
        mapped = 1'b1;
        rd     = {16'h0000, q.tx_good};
      end
      `EMF_OFF_STATUS:
      begin
        mapped = 1'b1;
        rd     = {30'h00000000, q.tx_st != TX_IDLE, q.rx_n != 16'h0000};
      end
      default:
      begin
        mapped = 1'b0;
        rd     = 32'h0000_0000;
      end
    endcase
    if (apb_req.psel && !apb_req.penable)
      d.prdata = rd;
    if (apb_req.psel && apb_req.penable && apb_req.pwrite)
    begin
      if (apb_req.paddr == `EMF_OFF_CFG)
        d.cfg = emf_cfg_t'(apb_req.pwdata[`EMF_CFG_W-1:0]);
      if (apb_req.paddr == `EMF_OFF_MAXLEN)
        d.maxlen = apb_req.pwdata[15:0];
    end
    apb_rsp.prdata  = q.prdata;
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

    // ****************************************************************
    // receive path
    // ****************************************************************
    d.rx_axis.tvalid    = 1'b0;
    d.rx_axis.tlast     = 1'b0;
    d.rx_axis.tuser     = 1'b0;
    d.rx_stat_v         = 1'b0;
    d.rx_stat.byte_seen = rx_phy.valid;
    if (rx_phy.valid)
    begin
      d.rx_sr = {q.rx_sr[23:0], rx_phy.data};
      if (q.rx_n != 16'hFFFF)
        d.rx_n = q.rx_n + 16'h0001;
      rej_now = q.rx_rej || (idx < `EMF_DA_BYTES && rx_phy.filter_reject);
      d.rx_rej = rej_now;
      if (idx == 16'h000C)
        d.rx_lt[15:8] = rx_phy.data;
      if (idx == 16'h000D)
      begin
        d.rx_lt[7:0] = rx_phy.data;
        d.rx_vlan    = ({q.rx_lt[15:8], rx_phy.data} == `EMF_VLAN_TPID);
      end
      // pass mode delivers every byte; otherwise the last four stay behind
      if (q.cfg.rx_fcs_pass)
      begin
        has_cand = 1'b1;
        ci       = idx;
        cand     = rx_phy.data;
      end
      else if (idx >= `EMF_FCS_BYTES)
      begin
        has_cand = 1'b1;
        ci       = idx - `EMF_FCS_BYTES;
        cand     = q.rx_sr[31:24];
      end
      strip = q.cfg.lt_check_en && !q.cfg.rx_fcs_pass && !q.rx_vlan &&
              ci >= `EMF_HDR_BYTES && q.rx_lt < `EMF_LEN_MIN_FIELD &&
              ci >= (`EMF_HDR_BYTES + q.rx_lt);
      if (has_cand && !strip)
      begin
        if (q.pend_v)
        begin
          d.rx_axis.tdata  = q.pend_d;
          d.rx_axis.tvalid = !rej_now;
        end
        d.pend_v = 1'b1;
        d.pend_d = cand;
      end
    end
    else if (rx_phy.frame_end)
    begin
      if (!q.cfg.jumbo_en)
        oversz = q.rx_n > (q.rx_vlan ? `EMF_MAX_TAGGED : `EMF_MAX_UNTAGGED);
      if (!q.cfg.jumbo_en && q.cfg.maxlen_en && q.rx_n > q.maxlen)
        oversz = 1'b1;
      if (!q.rx_vlan)
      begin
        if (q.rx_lt < `EMF_LEN_MIN_FIELD && q.rx_n != `EMF_MIN_FRAME)
          lterr = 1'b1;
        if (q.cfg.lt_check_en && q.rx_lt >= `EMF_LEN_MIN_FIELD &&
            q.rx_lt < `EMF_LEN_TYPE_SPLIT &&
            (q.rx_n - `EMF_HDR_FCS_BYTES) != q.rx_lt)
          lterr = 1'b1;
      end
      err = rx_phy.fcs_bad || rx_phy.phy_err || oversz || lterr ||
            q.rx_n < `EMF_MIN_FRAME;
      d.rx_axis.tdata     = q.pend_d;
      d.rx_axis.tvalid    = q.pend_v && !q.rx_rej;
      d.rx_axis.tlast     = q.pend_v && !q.rx_rej;
      d.rx_axis.tuser     = q.pend_v && !q.rx_rej && err;
      d.rx_stat.length    = q.rx_n;
      d.rx_stat.vlan      = q.rx_vlan;
      d.rx_stat.fcs_err   = rx_phy.fcs_bad;
      d.rx_stat.size_err  = oversz || q.rx_n < `EMF_MIN_FRAME;
      d.rx_stat.lt_err    = lterr;
      d.rx_stat.filtered  = q.rx_rej;
      d.rx_stat.good      = !err && !q.rx_rej;
      d.rx_stat_v         = 1'b1;
      if (!err && !q.rx_rej)
        d.rx_good = q.rx_good + 16'h0001;
      else
        d.rx_bad = q.rx_bad + 16'h0001;
      d.rx_n    = 16'h0000;
      d.rx_lt   = 16'hFFFF;
      d.rx_vlan = 1'b0;
      d.rx_rej  = 1'b0;
      d.pend_v  = 1'b0;
    end

    // ****************************************************************
    // transmit path: byte tick per speed
    // ****************************************************************
    case (q.cfg.speed)
      2'b01:   div = `EMF_DIV_100M;
      2'b10:   div = `EMF_DIV_10M;
      default: div = `EMF_DIV_1G;
    endcase
    d.tick_cnt  = tick ? div - 7'h01 : q.tick_cnt - 7'h01;
    d.tx_stat_v = 1'b0;
    case (q.tx_st)
      TX_FILL:  tready_c = 1'b1;
      TX_SEND:  tready_c = tick && !q.got_last;
      default:  tready_c = 1'b0;
    endcase
    tx_tready = tready_c;
    if (tick && q.tx_st != TX_SEND && q.tx_st != TX_PAD && q.tx_st != TX_ERRF)
    begin
      d.tx_phy.tx_en = 1'b0;
      d.tx_phy.tx_er = 1'b0;
      d.tx_phy.txd   = 8'h00;
    end
    d.tx_phy.append_fcs = !q.cfg.tx_fcs_pass;
    case (q.tx_st)
      TX_IDLE:
      begin
        if (tx_axis.tvalid)
        begin
          d.tx_st    = TX_FILL;
          d.buf_n    = 2'd0;
          d.got_last = 1'b0;
          d.aborted  = 1'b0;
          d.tx_cnt   = 16'h0000;
        end
      end
      TX_FILL:
      begin
        if (!tx_axis.tvalid)
        begin
          d.aborted = 1'b1;
          d.tx_st   = TX_WAIT;
        end
        else
        begin
          d.tx_buf = {q.tx_buf[7:0], tx_axis.tdata};
          d.buf_n  = q.buf_n + 2'd1;
          if (tx_axis.tuser)
            d.aborted = 1'b1;
          if (tx_axis.tlast)
            d.got_last = 1'b1;
          if (tx_axis.tuser || tx_axis.tlast || q.buf_n == 2'd1)
            d.tx_st = TX_WAIT;
        end
      end
      TX_WAIT:
      begin
        if (q.aborted && tx_axis.tvalid)
        begin
          d.tx_st    = TX_FILL;
          d.aborted  = 1'b0;
          d.buf_n    = 2'd0;
          d.got_last = 1'b0;
        end
        else if (tick)
        begin
          d.tx_cnt = 16'h0000;
          d.tx_st  = q.aborted ? TX_ERRF : TX_SEND;
        end
      end
      TX_SEND:
      begin
        if (tick)
        begin
          d.tx_phy.txd   = (q.buf_n == 2'd2) ? q.tx_buf[15:8] : q.tx_buf[7:0];
          d.tx_phy.tx_en = 1'b1;
          d.tx_phy.tx_er = 1'b0;
          d.tx_cnt       = q.tx_cnt + 16'h0001;
          if (!q.got_last)
          begin
            if (!tx_axis.tvalid || tx_axis.tuser)
            begin
              d.tx_phy.tx_er       = 1'b1;
              d.tx_st              = TX_IFG;
              d.ifg_cnt            = 4'h0;
              d.tx_stat.length     = q.tx_cnt + 16'h0001;
              d.tx_stat.good       = 1'b0;
              d.tx_stat.underrun   = !tx_axis.tvalid;
              d.tx_stat.user_abort = tx_axis.tvalid;
              d.tx_stat_v          = 1'b1;
            end
            else
            begin
              d.tx_buf = {q.tx_buf[7:0], tx_axis.tdata};
              if (tx_axis.tlast)
                d.got_last = 1'b1;
            end
          end
          else
          begin
            d.buf_n = q.buf_n - 2'd1;
            if (q.buf_n == 2'd1)
            begin
              if (q.tx_cnt + 16'h0001 < min_len)
                d.tx_st = TX_PAD;
              else
              begin
                d.tx_st              = TX_IFG;
                d.ifg_cnt            = 4'h0;
                d.tx_stat.length     = q.tx_cnt + 16'h0001;
                d.tx_stat.good       = 1'b1;
                d.tx_stat.underrun   = 1'b0;
                d.tx_stat.user_abort = 1'b0;
                d.tx_stat_v          = 1'b1;
                d.tx_good            = q.tx_good + 16'h0001;
              end
            end
          end
        end
      end
      TX_PAD:
      begin
        if (tick)
        begin
          d.tx_phy.txd   = 8'h00;
          d.tx_phy.tx_en = 1'b1;
          d.tx_phy.tx_er = 1'b0;
          d.tx_cnt       = q.tx_cnt + 16'h0001;
          if (q.tx_cnt + 16'h0001 >= min_len)
          begin
            d.tx_st              = TX_IFG;
            d.ifg_cnt            = 4'h0;
            d.tx_stat.length     = q.tx_cnt + 16'h0001;
            d.tx_stat.good       = 1'b1;
            d.tx_stat.underrun   = 1'b0;
            d.tx_stat.user_abort = 1'b0;
            d.tx_stat_v          = 1'b1;
            d.tx_good            = q.tx_good + 16'h0001;
          end
        end
      end
      TX_ERRF:
      begin
        if (tick)
        begin
          d.tx_phy.txd   = 8'h00;
          d.tx_phy.tx_en = 1'b1;
          d.tx_phy.tx_er = 1'b1;
          d.tx_cnt       = q.tx_cnt + 16'h0001;
          if (q.tx_cnt + 16'h0001 >= MIN_ERR_LEN)
          begin
            d.tx_st              = TX_IFG;
            d.ifg_cnt            = 4'h0;
            d.tx_stat.length     = q.tx_cnt + 16'h0001;
            d.tx_stat.good       = 1'b0;
            d.tx_stat.underrun   = 1'b0;
            d.tx_stat.user_abort = 1'b1;
            d.tx_stat_v          = 1'b1;
          end
        end
      end
      TX_IFG:
      begin
        if (tick)
        begin
          d.ifg_cnt = q.ifg_cnt + 4'h1;
          if (q.ifg_cnt + 4'h1 >= IFG_BYTES)
            d.tx_st = TX_IDLE;
        end
      end
      default:
        d.tx_st = TX_IDLE;
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q             <= '0;
      q.cfg         <= emf_cfg_t'(`EMF_CFG_RESET);
      q.maxlen      <= `EMF_MAXLEN_RESET;
      q.rx_lt       <= 16'hFFFF;
      q.tx_st       <= TX_IDLE;
      q.tx_phy.append_fcs <= 1'b1;
    end
    else
      q <= d;
  end

  // receive side has no stall input: data is pushed every cycle it arrives
  assign rx_axis       = q.rx_axis;
  assign rx_stat       = q.rx_stat;
  assign rx_stat_valid = q.rx_stat_v;
  assign tx_phy        = q.tx_phy;
  assign tx_stat       = q.tx_stat;
  assign tx_stat_valid = q.tx_stat_v;

endmodule : emf_framing

`default_nettype wire

// ---- tb/emf_chk.sv ----
/* Port checker of emf_framing, bound onto every instance.
   Assumes one clock pclk and its reset presetn. */
`timescale 1ns/100ps
`default_nettype none
module emf_chk
  import emf_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire emf_pkg::emf_rx_phy_t  rx_phy,
  input wire emf_pkg::emf_axis_t    rx_axis,
  input wire emf_pkg::emf_rx_stat_t rx_stat,
  input wire logic                  rx_stat_valid,
  input wire emf_pkg::emf_axis_t    tx_axis,
  input wire logic                  tx_tready,
  input wire emf_pkg::emf_tx_phy_t  tx_phy
);
  logic in_q;
  logic rej_q;
  // rej_q marks a frame rejected from its first byte
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      in_q  <= 1'b0;
      rej_q <= 1'b0;
    end
    else
    begin
      in_q  <= !rx_phy.frame_end && (in_q || rx_phy.valid);
      rej_q <= !rx_stat_valid && (rej_q || (rx_phy.valid && !in_q && rx_phy.filter_reject));
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rej_end;
    rej_q && rx_phy.frame_end;
  endsequence
  sequence s_stat_pulse;
    rx_stat_valid ##1 !rx_stat_valid;
  endsequence
  AST_BYTE_SEEN: assert property (rx_phy.valid |=> rx_stat.byte_seen)
    else $error("byte seen missing");
  AST_STAT_PULSE: assert property (rx_phy.frame_end |=> s_stat_pulse)
    else $error("stats strobe wrong");
  AST_LAST_END: assert property (rx_axis.tlast |->
    rx_axis.tvalid && $past(rx_phy.frame_end))
    else $error("last byte mistimed");
  AST_FCS_BAD: assert property (rx_phy.frame_end && rx_phy.fcs_bad |=>
    rx_stat.fcs_err && !rx_stat.good && (rx_axis.tuser || !rx_axis.tvalid))
    else $error("fcs failure not flagged");
  AST_SHORT_BAD: assert property (rx_stat_valid && rx_stat.length < 16'h0040 |->
    !rx_stat.good)
    else $error("short frame good");
  AST_REJ_HIDE: assert property (rej_q |-> !rx_axis.tvalid)
    else $error("rejected frame shown");
  AST_REJ_STAT: assert property (s_rej_end |=> rx_stat_valid && rx_stat.filtered)
    else $error("rejected frame stats missing");
  AST_TX_ABORT: assert property (tx_tready && tx_axis.tvalid && tx_axis.tuser &&
    tx_phy.tx_en |-> ##[1:300] tx_phy.tx_er)
    else $error("user abort not corrupted");
  AST_UNDERRUN: assert property (tx_tready && !tx_axis.tvalid && tx_phy.tx_en |->
    ##[1:300] tx_phy.tx_er)
    else $error("underrun not corrupted");
endmodule : emf_chk
bind emf_framing emf_chk emf_chk_inst (.pclk(pclk), .presetn(presetn), .rx_phy(rx_phy),
  .rx_axis(rx_axis), .rx_stat(rx_stat), .rx_stat_valid(rx_stat_valid),
  .tx_axis(tx_axis), .tx_tready(tx_tready), .tx_phy(tx_phy));
`default_nettype wire

// ---- tb/emf_user_model.sv ----
/* User logic model: frame source on transmit, sink on receive.
   Assumes start pulses while idle; bytes carry their index. */
`timescale 1ns/100ps
`default_nettype none
module emf_user_model
  import emf_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               start,
  input  wire logic [15:0]        len,
  input  wire logic [15:0]        drop_at,
  input  wire logic [15:0]        err_at,
  input  wire logic               tx_tready,
  input  wire emf_pkg::emf_axis_t rx_axis,
  output var  emf_pkg::emf_axis_t tx_axis,
  output logic                    busy,
  output logic [15:0]             rx_n
);
  logic [15:0] idx;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      idx  <= 16'h0000;
      busy <= 1'b0;
      rx_n <= 16'h0000;
    end
    else
    begin
      if (start)
      begin
        idx  <= 16'h0000;
        busy <= 1'b1;
      end
      else if (busy && tx_tready)
      begin
        idx  <= idx + 16'h0001;
        busy <= !(tx_axis.tlast || tx_axis.tuser || !tx_axis.tvalid);
      end
      if (rx_axis.tvalid)
        rx_n <= rx_n + 16'h0001;
    end
  always_comb
  begin
    tx_axis.tvalid = busy && idx != drop_at;
    tx_axis.tdata  = tx_axis.tvalid ? idx[7:0] : ~idx[7:0];
    tx_axis.tlast  = busy && idx == len - 16'h0001;
    tx_axis.tuser  = busy && idx == err_at;
  end
endmodule : emf_user_model
`default_nettype wire

// ---- tb/testbench.sv ----
/* Self-checking bench of emf_framing with the user model.
   Assumes design, package, model and checker compiled before. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import emf_pkg::*;
  logic         pclk;
  logic         presetn = 1'b0;
  emf_apb_req_t apb_req = '0;
  emf_apb_rsp_t apb_rsp;
  emf_rx_phy_t  rx_phy = '0;
  emf_axis_t    rx_axis;
  emf_rx_stat_t rx_stat;
  emf_axis_t    tx_axis;
  emf_tx_phy_t  tx_phy;
  emf_tx_stat_t tx_stat;
  logic         rx_stat_valid;
  logic         tx_tready;
  logic         tx_stat_valid;
  logic         start = 1'b0;
  logic         busy;
  logic [15:0]  len = 16'h0000;
  logic [15:0]  drop_at = 16'hFFFF;
  logic [15:0]  err_at = 16'hFFFF;
  logic [15:0]  rx_n;
  logic [31:0]  q;
  logic         e;
  int           n_mismatch = 0;
  int           check_count = 0;
  int           cyc = 0;
  emf_framing emf_framing_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .rx_phy(rx_phy), .rx_axis(rx_axis), .rx_stat(rx_stat),
    .rx_stat_valid(rx_stat_valid), .tx_axis(tx_axis), .tx_tready(tx_tready),
    .tx_phy(tx_phy), .tx_stat(tx_stat), .tx_stat_valid(tx_stat_valid));
  emf_user_model emf_user_model_inst (.pclk(pclk), .presetn(presetn), .start(start),
    .len(len), .drop_at(drop_at), .err_at(err_at), .tx_tready(tx_tready),
    .rx_axis(rx_axis), .tx_axis(tx_axis), .busy(busy), .rx_n(rx_n));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    apb_req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1)
      @(posedge pclk);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    // one idle edge so that back-to-back calls never assign the bus twice at once
    @(posedge pclk);
  endtask : apb
  function automatic logic [7:0] byte_at(input int i, input logic [15:0] lt, input bit vl);
    if (vl && i == 12)
      return 8'h81;
    if (vl && i == 13)
      return 8'h00;
    if (i == (vl ? 16 : 12))
      return lt[15:8];
    if (i == (vl ? 17 : 13))
      return lt[7:0];
    return i[7:0];
  endfunction : byte_at
  // one received frame at full rate, then stats and delivered byte count
  task automatic rx(input logic [7:0] c, input int n, input logic [15:0] lt,
                    input bit vl, fb, rj, ok);
    logic [15:0] n0;
    int          x;
    apb(1'b1, 8'h00, {24'h0, c}, q, e);
    n0 = rx_n;
    for (int i = 0; i < n; i++)
    begin
      rx_phy <= '{1'b1, byte_at(i, lt, vl), 1'b0, 1'b0, 1'b0, rj && i < 6};
      @(posedge pclk);
    end
    rx_phy <= '{1'b0, 8'h00, 1'b1, fb, 1'b0, 1'b0};
    @(posedge pclk);
    rx_phy.frame_end <= 1'b0;
    @(negedge pclk);
    chk(rx_stat_valid, 1'b1);
    chk(rx_stat.good, ok);
    chk(rx_stat.filtered, rj);
    chk(rx_stat.length, 32'(n));
    chk(rx_stat.vlan, vl);
    repeat (4) @(posedge pclk);
    x = rj ? 0 : c[0] ? n : (c[3] && !vl && lt < 46) ? 14 + lt : n - 4;
    chk(rx_n - n0, 32'(x));
  endtask : rx
  // one transmitted frame: wire bytes, error code and ready spacing
  task automatic tx(input logic [7:0] c, input int n, d, u, input bit rep, ok,
                    input int en, gap);
    int   k = 0;
    int   t = 0;
    int   ne = 0;
    int   bad = 0;
    logic er = 1'b0;
    bit   s;
    bit   dn = 1'b0;
    apb(1'b1, 8'h00, {24'h0, c}, q, e);
    len <= 16'(n);
    drop_at <= 16'(d);
    err_at <= 16'(u);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    while (tx_stat_valid !== 1'b1)
    begin
      @(posedge pclk);
      ne += tx_phy.tx_en;
      er |= tx_phy.tx_er;
      t++;
      if (tx_tready && tx_axis.tvalid)
      begin
        k++;
        if (gap > 0 && ((k == 2 && t != 1) || (k > 3 && t != gap)))
          bad++;
        t = 0;
      end
      // replacement must stand on the bus in the cycle right after the abort
      s = rep && k == 1 && !dn;
      if (dn)
        err_at <= 16'hFFFF;
      dn |= s;
      start <= s;
    end
    chk(tx_stat.good, ok);
    chk(tx_stat.underrun, d < n);
    chk(tx_stat.user_abort, !ok && d >= n);
    chk(busy, 1'b0);
    repeat (20)
    begin
      @(posedge pclk);
      ne += tx_phy.tx_en;
      er |= tx_phy.tx_er;
    end
    chk(er, !ok);
    chk(32'(bad), 0);
    if (en > 0)
      chk(32'(ne), 32'(en));
  endtask : tx
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h00000008);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk(q, 32'h000005EE);
    apb(1'b1, 8'h40, 32'h0000000F, q, e);
    chk(e, 1'b1);
    apb(1'b1, 8'h04, 32'h00000064, q, e);
    rx(8'h08, 64, 16'h0010, 0, 0, 0, 1);
    rx(8'h08, 70, 16'h0010, 0, 0, 0, 0);
    rx(8'h08, 66, 16'h0030, 0, 0, 0, 1);
    rx(8'h08, 70, 16'h0030, 0, 0, 0, 0);
    rx(8'h00, 70, 16'h0030, 0, 0, 0, 1);
    rx(8'h00, 64, 16'h0010, 0, 0, 0, 1);
    rx(8'h00, 60, 16'h0010, 0, 0, 0, 0);
    rx(8'h09, 64, 16'h0010, 0, 0, 0, 1);
    rx(8'h09, 64, 16'h0010, 0, 1, 0, 0);
    rx(8'h08, 70, 16'h0030, 1, 0, 0, 1);
    rx(8'h08, 1518, 16'h0800, 0, 0, 0, 1);
    rx(8'h08, 1519, 16'h0800, 0, 0, 0, 0);
    rx(8'h08, 1522, 16'h0800, 1, 0, 0, 1);
    rx(8'h08, 1523, 16'h0800, 1, 0, 0, 0);
    rx(8'h0A, 1523, 16'h0800, 0, 0, 0, 1);
    rx(8'h0C, 101, 16'h0800, 0, 0, 0, 0);
    rx(8'h0C, 100, 16'h0800, 0, 0, 0, 1);
    rx(8'h0E, 101, 16'h0800, 0, 0, 0, 1);
    rx(8'h08, 64, 16'h0800, 0, 0, 1, 0);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk(q, 32'h0000000B);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk(q, 32'h00000008);
    tx(8'h08, 20, 999, 999, 0, 1, 60, 1);
    tx(8'h18, 20, 999, 999, 0, 1, 64, 1);
    tx(8'h28, 20, 999, 999, 0, 1, 0, 10);
    tx(8'h48, 8, 999, 999, 0, 1, 0, 100);
    tx(8'h08, 60, 30, 999, 0, 0, 0, 1);
    tx(8'h08, 60, 999, 30, 0, 0, 0, 1);
    tx(8'h08, 20, 999, 1, 1, 1, 60, 0);
    tx(8'h08, 20, 999, 1, 0, 0, 0, 1);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk(q, 32'h00000005);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
